// ---- hw/pcs_pkg.sv ----
// Shared constants and types for the program counter and return stack unit
package pcs_pkg;
  localparam int PCS_PC_W = 11;
  localparam int PCS_STK_DEPTH = 8;
  localparam int PCS_SP_W = 3;
  localparam int PCS_PAGE_W = 10;
  localparam int PCS_LOW_W = 8;
  localparam int PCS_ACC_W = 8;
  localparam int PCS_RSEL_W = 8;
  localparam int PCS_DADDR_W = 8;
  localparam logic [PCS_PC_W-1:0] PCS_PC_RST = 11'h000;
  localparam logic [PCS_SP_W-1:0] PCS_SP_RST = 3'h0;
  localparam logic [3:0] PCS_DIV_RST = 4'h0;
  localparam int PCS_REG_LSB = 0;
  localparam int PCS_REG_MSB = 5;
  localparam int PCS_BANK_LSB = 6;
  localparam int PCS_BANK_MSB = 7;
  localparam logic [5:0] PCS_IND_ADDR = 6'h00;

  // Clocks per instruction cycle selector: 2, 4, 8 or 16
  typedef enum logic [1:0] {
    PCS_CPI_2 = 2'b00,
    PCS_CPI_4 = 2'b01,
    PCS_CPI_8 = 2'b10,
    PCS_CPI_16 = 2'b11
  } pcs_cpi_e;

  typedef enum logic [2:0] {
    PCS_OP_NEXT = 3'b000,
    PCS_OP_PAGE_BRANCH = 3'b001,
    PCS_OP_PAGE_CALL = 3'b010,
    PCS_OP_FAR_BRANCH = 3'b011,
    PCS_OP_FAR_CALL = 3'b100,
    PCS_OP_POP = 3'b101,
    PCS_OP_ACC_SUM = 3'b110,
    PCS_OP_PC_WRITE = 3'b111
  } pcs_op_e;

  typedef enum logic {
    PCS_ST_RUN = 1'b0,
    PCS_ST_FLUSH = 1'b1
  } pcs_state_e;
endpackage : pcs_pkg

// ---- hw/pcs_cycle_div.sv ----
// Instruction cycle divider producing a one-clock end-of-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module pcs_cycle_div
  import pcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire pcs_pkg::pcs_cpi_e cpi_sel,
  // Pulse
  output logic cyc_end
);
  import pcs_pkg::*;

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] last;

  always_comb begin
    unique case (cpi_sel)
      PCS_CPI_2: last = 4'h1;
      PCS_CPI_4: last = 4'h3;
      PCS_CPI_8: last = 4'h7;
      PCS_CPI_16: last = 4'hF;
    endcase
    cnt_nxt = (cnt_r >= last) ? PCS_DIV_RST : cnt_r + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= PCS_DIV_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cyc_end = (cnt_r >= last);

  // A selector change mid-cycle may legally shorten a cycle, so both checks need it held
  sequence s_fast_end;
    cyc_end && cpi_sel == PCS_CPI_2;
  endsequence

  a_div_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_fast_end ##1 (cpi_sel == PCS_CPI_2) |-> !cyc_end)
    else $error("instruction cycle shorter than two clocks");
  a_div_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_fast_end ##1 (cpi_sel == PCS_CPI_2) [*2] |-> cyc_end)
    else $error("instruction cycle not two clocks");
endmodule : pcs_cycle_div
`default_nettype wire

// ---- hw/pcs_sequencer.sv ----
// Program counter, eight-deep return stack and indirect address path
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int STK_DEPTH = PCS_STK_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration option
  input wire pcs_pkg::pcs_cpi_e cpi_sel,
  // Decoder request, sampled at the end of each instruction cycle except the discard cycle
  input wire pcs_pkg::pcs_op_e op,
  input wire logic [PCS_PC_W-1:0] operand,
  input wire logic [PCS_ACC_W-1:0] acc,
  input wire logic [PCS_LOW_W-1:0] pc_wr_data,
  // Data register access path
  input wire logic [5:0] dreg_addr,
  input wire logic [PCS_RSEL_W-1:0] ram_select_register,
  output logic [PCS_DADDR_W-1:0] dreg_eff_addr,
  // Program memory
  output logic [PCS_PC_W-1:0] fetch_addr,
  output logic cyc_end,
  output logic flush
);
  import pcs_pkg::*;

  logic [PCS_PC_W-1:0] pc_r;
  logic [PCS_PC_W-1:0] pc_nxt;
  logic [PCS_SP_W-1:0] sp_r;
  logic [PCS_SP_W-1:0] sp_nxt;
  logic [PCS_PC_W-1:0] stk_r [STK_DEPTH];
  logic push;
  pcs_state_e st_r;
  pcs_state_e st_nxt;
  logic [PCS_PC_W-1:0] pc_inc;
  logic [PCS_SP_W-1:0] sp_top;

  pcs_cycle_div u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cpi_sel(cpi_sel),
    .cyc_end(cyc_end)
  );

  // Bank in the upper bits, register number below; data reg storage lives elsewhere
  always_comb begin
    if (dreg_addr == PCS_IND_ADDR) begin
      dreg_eff_addr = ram_select_register;
    end else begin
      dreg_eff_addr = {ram_select_register[PCS_BANK_MSB:PCS_BANK_LSB], dreg_addr};
    end
  end

  assign pc_inc = pc_r + 11'h001;
  assign sp_top = sp_r - 3'h1;

  always_comb begin
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    push = 1'b0;
    st_nxt = st_r;
    if (cyc_end) begin
      unique case (st_r)
        // Fetched word is discarded; counter already points at target
        PCS_ST_FLUSH: st_nxt = PCS_ST_RUN;
        PCS_ST_RUN: begin
          st_nxt = (op == PCS_OP_NEXT) ? PCS_ST_RUN : PCS_ST_FLUSH;
          unique case (op)
            PCS_OP_NEXT: pc_nxt = pc_inc;
            PCS_OP_PAGE_BRANCH:
              pc_nxt = {pc_r[PCS_PC_W-1], operand[PCS_PAGE_W-1:0]};
            PCS_OP_PAGE_CALL: begin
              push = 1'b1;
              pc_nxt = {pc_r[PCS_PC_W-1], operand[PCS_PAGE_W-1:0]};
            end
            PCS_OP_FAR_BRANCH: pc_nxt = operand;
            PCS_OP_FAR_CALL: begin
              push = 1'b1;
              pc_nxt = operand;
            end
            PCS_OP_POP: begin
              pc_nxt = stk_r[sp_top];
              sp_nxt = sp_top;
            end
            PCS_OP_ACC_SUM: pc_nxt = pc_r + {3'h0, acc};
            // Bits 8 to 10 kept; write covers moves and bit clears alike
            PCS_OP_PC_WRITE:
              pc_nxt = {pc_r[PCS_PC_W-1:PCS_LOW_W], pc_wr_data};
          endcase
          // Pointer wraps modulo depth: deepest entry silently replaced
          if (push) sp_nxt = sp_r + 3'h1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= PCS_PC_RST;
      sp_r <= PCS_SP_RST;
      st_r <= PCS_ST_RUN;
    end else begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      st_r <= st_nxt;
    end
  end

  // Stack storage has no reset; contents are undefined until pushed
  always_ff @(posedge sys_clk) begin
    if (push) stk_r[sp_r] <= pc_inc;
  end

  assign fetch_addr = pc_r;
  assign flush = (st_r == PCS_ST_FLUSH);

  sequence s_call_taken;
    cyc_end && st_r == PCS_ST_RUN && (op == PCS_OP_PAGE_CALL || op == PCS_OP_FAR_CALL);
  endsequence

  sequence s_change_taken;
    cyc_end && !flush && op != PCS_OP_NEXT;
  endsequence

  sequence s_flush_mid;
    flush && !cyc_end;
  endsequence

  sequence s_flush_last;
    flush && cyc_end;
  endsequence

  a_step_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cyc_end && !flush && op == PCS_OP_NEXT) |=> fetch_addr == $past(fetch_addr) + 11'h001)
    else $error("counter did not step by one");
  a_page_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cyc_end && !flush && (op == PCS_OP_PAGE_BRANCH || op == PCS_OP_PAGE_CALL)) |=>
      fetch_addr == {$past(fetch_addr[10]), $past(operand[9:0])})
    else $error("page branch target wrong");
  a_far_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cyc_end && !flush && (op == PCS_OP_FAR_BRANCH || op == PCS_OP_FAR_CALL)) |=>
      fetch_addr == $past(operand))
    else $error("far branch target wrong");
  a_call_push: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_call_taken |=> stk_r[$past(sp_r)] == $past(fetch_addr) + 11'h001)
    else $error("call pushed wrong return address");
  a_push_depth: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_call_taken |=> sp_r == $past(sp_r) + 3'h1)
    else $error("call did not advance stack pointer");
  a_pop_ptr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cyc_end && !flush && op == PCS_OP_POP) |=> sp_r == $past(sp_r) - 3'h1)
    else $error("return did not pop stack");
  a_acc_sum: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cyc_end && !flush && op == PCS_OP_ACC_SUM) |=>
      fetch_addr == $past(fetch_addr) + {3'h0, $past(acc)})
    else $error("accumulator sum wrong");
  a_pc_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cyc_end && !flush && op == PCS_OP_PC_WRITE) |=>
      fetch_addr[10:8] == $past(fetch_addr[10:8]) && fetch_addr[7:0] == $past(pc_wr_data))
    else $error("pc write changed upper bits");
  a_flush_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_change_taken |=> flush)
    else $error("no extra cycle after pc change");
  a_flush_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_flush_mid |=> flush)
    else $error("extra cycle ended early");
  a_flush_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_flush_last |=> !flush)
    else $error("extra cycle lasted too long");
  a_flush_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_flush_last |=> $stable(fetch_addr))
    else $error("request taken during extra cycle");
  a_ind_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dreg_addr == PCS_IND_ADDR |-> dreg_eff_addr == ram_select_register)
    else $error("indirect access not redirected");
  a_idle_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cyc_end |=> $stable(fetch_addr))
    else $error("counter moved mid cycle");
endmodule : pcs_sequencer
`default_nettype wire

// ---- testbench/pcs_prog_mem.sv ----
// Program memory model feeding fetched words back
`timescale 1ns/1ps
`default_nettype none
module pcs_prog_mem
  import pcs_pkg::*;
(
  // Fetch side
  input wire logic [PCS_PC_W-1:0] fetch_addr,
  output logic [12:0] word
);
  // Each word carries its own address, so a stale fetch shows up
  always_comb begin
    word = {2'h3, fetch_addr};
  end
endmodule : pcs_prog_mem
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the program counter and return stack unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  pcs_cpi_e cpi_sel = PCS_CPI_2;
  pcs_op_e op = PCS_OP_NEXT;
  logic [10:0] operand = 11'h000;
  logic [7:0] acc = 8'h00;
  logic [7:0] wr = 8'h00;
  logic [5:0] dreg = 6'h00;
  logic [7:0] rsel = 8'h00;
  logic [7:0] eff;
  logic [10:0] fa;
  logic cyc_end;
  logic flush;
  logic [12:0] word;
  logic [10:0] pc = 11'h000;
  int errors = 0;
  int comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  pcs_sequencer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cpi_sel(cpi_sel), .op(op),
    .operand(operand), .acc(acc), .pc_wr_data(wr), .dreg_addr(dreg),
    .ram_select_register(rsel), .dreg_eff_addr(eff), .fetch_addr(fa),
    .cyc_end(cyc_end), .flush(flush));
  pcs_prog_mem u_mem (.fetch_addr(fa), .word(word));
  task automatic chk(input string nm, input logic [10:0] s, input logic [10:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Free means the unit is not in its discard cycle
  task automatic wait_end(input logic free);
    int n;
    n = 0;
    while (!(cyc_end === 1'b1 && (flush === 1'b0 || !free))) begin
      @(negedge sys_clk);
      n++;
      if (n > 99) begin
        errors++;
        report_and_stop();
      end
    end
  endtask : wait_end
  task automatic go(input pcs_op_e o, input logic [10:0] d, input logic [10:0] e);
    wait_end(1'b1);
    op = o;
    operand = d;
    @(negedge sys_clk);
    op = PCS_OP_NEXT;
    pc = e;
    chk("fetch_addr", fa, e);
    chk("flush", {10'h000, flush}, {10'h000, o != PCS_OP_NEXT});
    chk("word", word[10:0], e);
  endtask : go
  task automatic t_basic();
    chk("reset pc", fa, 11'h000);
    go(PCS_OP_NEXT, 11'h7FF, 11'h001);
    go(PCS_OP_FAR_BRANCH, 11'h5A3, 11'h5A3);
    go(PCS_OP_PAGE_BRANCH, 11'h0F0, 11'h4F0);
    go(PCS_OP_NEXT, 11'h000, 11'h4F1);
    acc = 8'h20;
    go(PCS_OP_ACC_SUM, 11'h000, 11'h511);
    wr = 8'h3C;
    go(PCS_OP_PC_WRITE, 11'h000, 11'h53C);
  endtask : t_basic
  // A request in the discard cycle must leave the counter alone
  task automatic t_refuse();
    go(PCS_OP_FAR_BRANCH, 11'h200, 11'h200);
    wait_end(1'b0);
    op = PCS_OP_FAR_BRANCH;
    operand = 11'h055;
    @(negedge sys_clk);
    op = PCS_OP_NEXT;
    chk("refused", fa, 11'h200);
    go(PCS_OP_NEXT, 11'h000, 11'h201);
  endtask : t_refuse
  // Nine nested calls overrun the eight entries and wrap
  task automatic t_stack();
    logic [10:0] ret [9];
    logic [10:0] d;
    for (int i = 0; i < 9; i++) begin
      ret[i] = 11'(pc + 11'h001);
      d = 11'(11'h40C + i * 11'h0A1);
      if (i % 2 == 0) begin
        go(PCS_OP_PAGE_CALL, d, {pc[10], d[9:0]});
      end else begin
        go(PCS_OP_FAR_CALL, d, d);
      end
    end
    for (int i = 0; i < 9; i++) begin
      go(PCS_OP_POP, 11'h000, ret[(i == 8) ? 8 : 8 - i]);
    end
  endtask : t_stack
  task automatic t_indirect();
    @(negedge sys_clk);
    dreg = 6'h00;
    rsel = 8'hC5;
    #1;
    chk("indirect", {3'h0, eff}, 11'h0C5);
    @(negedge sys_clk);
    dreg = 6'h12;
    rsel = 8'h80;
    #1;
    chk("direct", {3'h0, eff}, 11'h092);
  endtask : t_indirect
  task automatic t_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    #1;
    chk("mid reset pc", fa, 11'h000);
    @(negedge sys_clk);
    rst_n = 1'b1;
    go(PCS_OP_NEXT, 11'h000, 11'h001);
  endtask : t_reset
  task automatic t_cpi();
    int n;
    for (int c = 0; c < 4; c++) begin
      cpi_sel = pcs_cpi_e'(c);
      wait_end(1'b0);
      @(negedge sys_clk);
      wait_end(1'b0);
      @(negedge sys_clk);
      n = 1;
      while (cyc_end !== 1'b1 && n < 40) begin
        @(negedge sys_clk);
        n++;
      end
      if (n >= 40) begin
        errors++;
        report_and_stop();
      end
      chk("cycle length", 11'(n), 11'(2 << c));
    end
  endtask : t_cpi
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    t_basic();
    t_refuse();
    t_stack();
    t_indirect();
    t_reset();
    t_cpi();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
